// ---- design/cbc_band_regs.sv ----
// i2c-reached band configuration registers and band-driven charge limits
`timescale 1ns/1ps
`default_nettype none

module cbc_band_regs #(
  parameter logic [6:0] SLAVE_ADDR = cbc_pkg::CBC_SLAVE_ADDR,
  parameter logic [7:0] BAND_RESET = cbc_pkg::CBC_BAND_RESET,
  parameter logic [7:0] CURR_RESET = cbc_pkg::CBC_CURR_RESET
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic signed [7:0] temp_c_in,
  input wire logic vbat_low_in,
  input wire logic [2:0] term_cold_code_in,
  input wire logic [2:0] term_normal_code_in,
  input wire logic [3:0] curr_warm_code_in,
  input wire logic [3:0] curr_hot_code_in,
  output var cbc_pkg::cbc_band_e band_out,
  output logic [12:0] term_mv_out,
  output logic [10:0] curr_limit_ma_out,
  output logic [10:0] eoc_ma_out,
  output logic charge_en_out,
  output logic temp_fault_out
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA
  } cbc_state_e;
  logic rst_q1_reg;
  logic rst_n;
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  cbc_state_e state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic ack_reg, ack_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic oe_reg, oe_next;
  logic cfg_en_reg, cfg_en_next;
  cbc_pkg::cbc_band_cfg_s band_reg, band_next;
  cbc_pkg::cbc_curr_cfg_s curr_reg, curr_next;
  cbc_pkg::cbc_chg_s chg_reg, chg_next;
  logic [7:0] rd_cur;
  logic [7:0] rd_inc;
  // reset release through two flops
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_q1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1_reg <= 1'b1;
      rst_n <= rst_q1_reg;
    end
  end

  // pin synchronisers plus one history stage for edges
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_sync_reg[2];
  assign scl_fall = ~scl_s & scl_sync_reg[2];
  assign start_det = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
  assign stop_det = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];
  function automatic logic [7:0] read_byte(
    input logic [7:0] addr,
    input logic en,
    input cbc_pkg::cbc_band_cfg_s band,
    input cbc_pkg::cbc_curr_cfg_s curr
  );
    logic [7:0] data;
    data = cbc_pkg::CBC_READ_ZERO;
    if (addr == cbc_pkg::CBC_ADDR_CFG_EN) begin
      data[cbc_pkg::CBC_CFG_EN_BIT] = en;
    end else if (en && addr == cbc_pkg::CBC_ADDR_BAND) begin
      data = band;
    end else if (en && addr == cbc_pkg::CBC_ADDR_CURR) begin
      data = curr;
    end
    return data;
  endfunction
  assign rd_cur = read_byte(ptr_reg, cfg_en_reg, band_reg, curr_reg);
  assign rd_inc = read_byte(8'(ptr_reg + 8'h01), cfg_en_reg, band_reg,
    curr_reg);

  // i2c slave and register file
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    ack_next = ack_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    oe_next = oe_reg;
    cfg_en_next = cfg_en_reg;
    band_next = band_reg;
    curr_next = curr_reg;
    if (start_det) begin
      state_next = ST_ADDR;
      bit_cnt_next = 4'h0;
      ack_next = 1'b0;
      oe_next = 1'b0;
    end else if (stop_det) begin
      state_next = ST_IDLE;
      ack_next = 1'b0;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && !ack_reg &&
              bit_cnt_reg < cbc_pkg::CBC_BYTE_BITS) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && ack_reg) begin
            ack_next = 1'b0;
            oe_next = 1'b0;
            bit_cnt_next = 4'h0;
            if (state_reg == ST_ADDR) begin
              if (rw_reg) begin
                state_next = ST_RDATA;
                shift_next = rd_cur;
                oe_next = ~rd_cur[7];
              end else begin
                state_next = ST_REG;
              end
            end else if (state_reg == ST_REG) begin
              state_next = ST_WDATA;
            end else begin
              ptr_next = ptr_reg + 8'h01;
            end
          end else if (scl_fall && bit_cnt_reg == cbc_pkg::CBC_BYTE_BITS) begin
            ack_next = 1'b1;
            oe_next = 1'b1;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == SLAVE_ADDR) begin
                rw_next = shift_reg[0];
              end else begin
                state_next = ST_IDLE;
                ack_next = 1'b0;
                oe_next = 1'b0;
              end
            end else if (state_reg == ST_REG) begin
              ptr_next = shift_reg;
            end else if (ptr_reg == cbc_pkg::CBC_ADDR_CFG_EN) begin
              cfg_en_next = shift_reg[cbc_pkg::CBC_CFG_EN_BIT];
            end else if (cfg_en_reg) begin
              if (ptr_reg == cbc_pkg::CBC_ADDR_BAND) begin
                band_next = shift_reg;
              end else if (ptr_reg == cbc_pkg::CBC_ADDR_CURR) begin
                curr_next = shift_reg;
              end
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            if (ack_reg) begin
              nack_next = sda_s;
            end else begin
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end else if (scl_fall) begin
            if (ack_reg) begin
              ack_next = 1'b0;
              bit_cnt_next = 4'h0;
              if (nack_reg) begin
                state_next = ST_IDLE;
              end else begin
                ptr_next = ptr_reg + 8'h01;
                shift_next = rd_inc;
                oe_next = ~rd_inc[7];
              end
            end else if (bit_cnt_reg == cbc_pkg::CBC_BYTE_BITS) begin
              ack_next = 1'b1;
              oe_next = 1'b0;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
            end
          end
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      ack_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg <= 1'b0;
      cfg_en_reg <= 1'b0;
      band_reg <= BAND_RESET;
      curr_reg <= CURR_RESET;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      ack_reg <= ack_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      oe_reg <= oe_next;
      cfg_en_reg <= cfg_en_next;
      band_reg <= band_next;
      curr_reg <= curr_next;
    end
  end
  // band selection and charge limits
  always_comb begin
    logic [2:0] term_code;
    logic [3:0] curr_code;
    term_code = term_cold_code_in;
    curr_code = curr_reg.curr_cold;
    chg_next = '0;
    if (temp_c_in <= cbc_pkg::CBC_T_COLD_HI_C) begin
      chg_next.band = cbc_pkg::CBC_BAND_COLD;
      term_code = term_cold_code_in;
      curr_code = curr_reg.curr_cold;
    end else if (temp_c_in <= cbc_pkg::CBC_T_NORM_HI_C) begin
      chg_next.band = cbc_pkg::CBC_BAND_NORMAL;
      term_code = term_normal_code_in;
      curr_code = curr_reg.curr_normal;
    end else if (temp_c_in <= cbc_pkg::CBC_T_WARM_HI_C) begin
      chg_next.band = cbc_pkg::CBC_BAND_WARM;
      term_code = band_reg.term_warm;
      curr_code = curr_warm_code_in;
    end else begin
      chg_next.band = cbc_pkg::CBC_BAND_HOT;
      term_code = band_reg.term_hot;
      curr_code = curr_hot_code_in;
    end
    chg_next.term_mv = cbc_pkg::CBC_TERM_MV[term_code];
    chg_next.eoc_ma = cbc_pkg::CBC_EOC_MA[band_reg.eoc];
    chg_next.curr_ma = vbat_low_in ? chg_next.eoc_ma :
      cbc_pkg::cbc_curr_ma(curr_code);
    chg_next.fault = (temp_c_in < cbc_pkg::CBC_T_MIN_C) ||
      (temp_c_in > cbc_pkg::CBC_T_MAX_C);
    chg_next.charge_en = !chg_next.fault &&
      (term_code != cbc_pkg::CBC_TERM_INVALID);
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chg_reg <= '0;
      sda_out <= 1'b0;
    end else begin
      chg_reg <= chg_next;
      sda_out <= 1'b0;
    end
  end
  assign sda_oe_out = oe_reg;
  assign band_out = chg_reg.band;
  assign term_mv_out = chg_reg.term_mv;
  assign curr_limit_ma_out = chg_reg.curr_ma;
  assign eoc_ma_out = chg_reg.eoc_ma;
  assign charge_en_out = chg_reg.charge_en;
  assign temp_fault_out = chg_reg.fault;
endmodule

`default_nettype wire

// ---- design/cbc_pkg.sv ----
// constants, types and lookups for the charger band configuration registers
package cbc_pkg;

  // i2c slave address and register offsets
  localparam logic [6:0] CBC_SLAVE_ADDR = 7'h48;
  localparam logic [7:0] CBC_ADDR_BAND = 8'h03;
  localparam logic [7:0] CBC_ADDR_CURR = 8'h04;
  localparam logic [7:0] CBC_ADDR_CFG_EN = 8'h11;
  localparam int CBC_CFG_EN_BIT = 0;
  localparam logic [7:0] CBC_READ_ZERO = 8'h00;
  localparam logic [7:0] CBC_BAND_RESET = 8'h00;
  localparam logic [7:0] CBC_CURR_RESET = 8'h00;
  localparam logic [3:0] CBC_BYTE_BITS = 4'h8;

  // temperature band edges in degrees c, each band owns its upper edge
  localparam logic signed [7:0] CBC_T_MIN_C = 8'sh00;
  localparam logic signed [7:0] CBC_T_COLD_HI_C = 8'sh0a;
  localparam logic signed [7:0] CBC_T_NORM_HI_C = 8'sh2d;
  localparam logic signed [7:0] CBC_T_WARM_HI_C = 8'sh32;
  localparam logic signed [7:0] CBC_T_MAX_C = 8'sh3c;

  // termination voltage in mv per code, code 7 is invalid
  localparam logic [2:0] CBC_TERM_INVALID = 3'h7;
  localparam logic [12:0] CBC_TERM_MV [8] = '{
    13'hf64, 13'hfa0, 13'hfd2, 13'h1004,
    13'h1018, 13'h1036, 13'h1054, 13'h0000
  };

  // end-of-charge current in ma per code
  localparam logic [10:0] CBC_EOC_MA [4] = '{
    11'h032, 11'h064, 11'h0b9, 11'h172
  };

  // charge current: 50 ma at code 0, else 100 ma per step
  localparam logic [10:0] CBC_CURR_MIN_MA = 11'h032;
  localparam logic [10:0] CBC_CURR_STEP_MA = 11'h064;

  typedef enum logic [1:0] {
    CBC_BAND_COLD, CBC_BAND_NORMAL, CBC_BAND_WARM, CBC_BAND_HOT
  } cbc_band_e;

  typedef struct packed {
    logic [1:0] eoc;
    logic [2:0] term_warm;
    logic [2:0] term_hot;
  } cbc_band_cfg_s;

  typedef struct packed {
    logic [3:0] curr_cold;
    logic [3:0] curr_normal;
  } cbc_curr_cfg_s;

  typedef struct packed {
    cbc_band_e band;
    logic [12:0] term_mv;
    logic [10:0] curr_ma;
    logic [10:0] eoc_ma;
    logic charge_en;
    logic fault;
  } cbc_chg_s;

  function automatic logic [10:0] cbc_curr_ma(input logic [3:0] code);
    return (code == 4'h0) ? CBC_CURR_MIN_MA :
      11'(11'(code) * CBC_CURR_STEP_MA);
  endfunction

endpackage

// ---- tb/cbc_i2c_host.sv ----
// i2c host model that programs and reads the band configuration bank
`timescale 1ns/1ps
`default_nettype none
module cbc_i2c_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // half scl phase, above the four-clock minimum
  task automatic hp();
    repeat (5) @(negedge clk_in);
  endtask
  task automatic bit_io(input logic b, output logic r);
    scl_out = 1'b0;
    hp();
    sda_oe_out = !b;
    hp();
    scl_out = 1'b1;
    hp();
    r = sda_in;
  endtask
  task automatic start();
    scl_out = 1'b0;
    hp();
    sda_oe_out = 1'b0;
    hp();
    scl_out = 1'b1;
    hp();
    sda_oe_out = 1'b1;
    hp();
  endtask
  task automatic stop();
    scl_out = 1'b0;
    hp();
    sda_oe_out = 1'b1;
    hp();
    scl_out = 1'b1;
    hp();
    sda_oe_out = 1'b0;
    hp();
  endtask
  task automatic xfer(input logic [7:0] d, input logic l,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(l, k);
  endtask
  task automatic wr_reg(input logic [6:0] sa, input logic [7:0] a,
                        input logic [7:0] v, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({sa, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    xfer(v, 1'b1, q, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v,
                        output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    start();
    xfer({cbc_pkg::CBC_SLAVE_ADDR, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    start();
    xfer({cbc_pkg::CBC_SLAVE_ADDR, 1'b1}, 1'b1, q, k2);
    xfer(8'hff, 1'b1, v, k3);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
  // two-byte read: master acks the first byte, nacks the second
  task automatic rd_two(input logic [7:0] a, output logic [15:0] v,
                        output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    start();
    xfer({cbc_pkg::CBC_SLAVE_ADDR, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    start();
    xfer({cbc_pkg::CBC_SLAVE_ADDR, 1'b1}, 1'b1, q, k2);
    xfer(8'hff, 1'b0, v[15:8], k3);
    xfer(8'hff, 1'b1, v[7:0], k3);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
endmodule
`default_nettype wire

// ---- tb/cbc_band_regs_asserts.sv ----
// concurrent checks on the band configuration register ports
`timescale 1ns/1ps
`default_nettype none
module cbc_band_regs_asserts (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic signed [7:0] temp_c_in,
  input wire logic vbat_low_in,
  input wire logic [2:0] term_cold_code_in,
  input wire logic [3:0] curr_warm_code_in,
  input var cbc_pkg::cbc_band_e band_out,
  input wire logic [12:0] term_mv_out,
  input wire logic [10:0] curr_limit_ma_out,
  input wire logic [10:0] eoc_ma_out,
  input wire logic charge_en_out,
  input wire logic temp_fault_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [1:0] up_reg, up_next;
  logic up;
  assign up = up_reg == 2'h3;
  always_comb up_next = up ? up_reg : up_reg + 2'h1;
  always_ff @(posedge core_clk_in or negedge rst_b_in)
    if (!rst_b_in) up_reg <= 2'h0;
    else up_reg <= up_next;
  flt_set_a: assert property (up && (temp_c_in < 8'sh00 ||
    temp_c_in > 8'sh3c) |=> temp_fault_out && !charge_en_out)
    else $error("fault not raised");
  flt_clr_a: assert property (up && temp_c_in >= 8'sh00 &&
    temp_c_in <= 8'sh3c |=> !temp_fault_out) else $error("false fault");
  band_cold_a: assert property (up && temp_c_in inside
    {[8'sh00:8'sh0a]} |=> band_out == cbc_pkg::CBC_BAND_COLD)
    else $error("cold band wrong");
  band_norm_a: assert property (up && temp_c_in inside
    {[8'sh0b:8'sh2d]} |=> band_out == cbc_pkg::CBC_BAND_NORMAL)
    else $error("normal band wrong");
  band_warm_a: assert property (up && temp_c_in inside
    {[8'sh2e:8'sh32]} |=> band_out == cbc_pkg::CBC_BAND_WARM)
    else $error("warm band wrong");
  band_hot_a: assert property (up && temp_c_in inside
    {[8'sh33:8'sh3c]} |=> band_out == cbc_pkg::CBC_BAND_HOT)
    else $error("hot band wrong");
  eoc_low_a: assert property (up && vbat_low_in |=>
    curr_limit_ma_out == eoc_ma_out) else $error("low vbat limit");
  eoc_set_a: assert property (up |-> eoc_ma_out inside
    {11'h032, 11'h064, 11'h0b9, 11'h172}) else $error("eoc value");
  term_bad_a: assert property (up && term_cold_code_in == 3'h7 &&
    temp_c_in inside {[8'sh00:8'sh0a]} |=> term_mv_out == 13'h0000 &&
    !charge_en_out) else $error("invalid term code");
  warm_curr_a: assert property (up && !vbat_low_in && temp_c_in
    inside {[8'sh2e:8'sh32]} |=> curr_limit_ma_out == (curr_warm_code_in
    == 4'h0 ? 11'h032 : 11'h064 * curr_warm_code_in))
    else $error("warm current");
  cover property (up && temp_fault_out);
  cover property (up && band_out == cbc_pkg::CBC_BAND_HOT);
  cover property (up && vbat_low_in);
endmodule
bind cbc_band_regs cbc_band_regs_asserts u_chk (.core_clk_in, .rst_b_in,
  .temp_c_in, .vbat_low_in, .term_cold_code_in, .curr_warm_code_in,
  .band_out, .term_mv_out, .curr_limit_ma_out, .eoc_ma_out,
  .charge_en_out, .temp_fault_out);
`default_nettype wire

// ---- tb/test_charger_band_config_regs.sv ----
// self-checking bench for the band configuration registers
`timescale 1ns/1ps
`default_nettype none
module test_charger_band_config_regs;
  typedef struct packed {
    logic signed [7:0] t;
    logic lo;
    logic [1:0] b;
    logic [12:0] mv;
    logic [10:0] ma;
    logic f;
  } cbc_row_s;
  logic clk = 1'b0, rst_b = 1'b0, lo = 1'b0, ok, h_oe, scl;
  logic sda_oe, sda_o, en, flt;
  logic signed [7:0] temp = 8'sh14;
  logic [2:0] tc = 3'h0;
  logic [7:0] d;
  logic [15:0] w;
  logic [12:0] mv;
  logic [10:0] ma, eoc;
  cbc_pkg::cbc_band_e band;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  wire logic sda = !(h_oe || (sda_oe && !sda_o));
  cbc_row_s rows [11] = '{
    '{8'sh00, 0, 0, 13'hf64, 11'h12c, 0},
    '{8'sh0a, 0, 0, 13'hf64, 11'h12c, 0},
    '{8'sh0b, 0, 1, 13'h1054, 11'h4b0, 0},
    '{8'sh2d, 0, 1, 13'h1054, 11'h4b0, 0},
    '{8'sh2e, 0, 2, 13'h1004, 11'h032, 0},
    '{8'sh32, 0, 2, 13'h1004, 11'h032, 0},
    '{8'sh33, 0, 3, 13'h1036, 11'h5dc, 0},
    '{8'sh3c, 0, 3, 13'h1036, 11'h5dc, 0},
    '{8'shff, 0, 0, 0, 0, 1},
    '{8'sh3d, 0, 0, 0, 0, 1},
    '{8'sh1e, 1, 1, 13'h1054, 11'h0b9, 0}};
  always #5 clk = !clk;
  cbc_i2c_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(h_oe));
  cbc_band_regs DUT (.core_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .temp_c_in(temp),
    .vbat_low_in(lo), .term_cold_code_in(tc), .term_normal_code_in(3'h6),
    .curr_warm_code_in(4'h0), .curr_hot_code_in(4'hf), .band_out(band),
    .term_mv_out(mv), .curr_limit_ma_out(ma), .eoc_ma_out(eoc),
    .charge_en_out(en), .temp_fault_out(flt));
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd_reg(a, d, ok);
    chk("register read", {8'h00, e}, {8'h00, d});
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.wr_reg(cbc_pkg::CBC_SLAVE_ADDR, a, v, ok);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    wr(cbc_pkg::CBC_ADDR_BAND, 8'h9d);
    chk("ack", 16'h0001, {15'h0000, ok});
    rdc(cbc_pkg::CBC_ADDR_BAND, 8'h00);
    wr(cbc_pkg::CBC_ADDR_CFG_EN, 8'h01);
    rdc(cbc_pkg::CBC_ADDR_CFG_EN, 8'h01);
    wr(cbc_pkg::CBC_ADDR_BAND, 8'h9d);
    wr(cbc_pkg::CBC_ADDR_CURR, 8'h3c);
    rdc(cbc_pkg::CBC_ADDR_BAND, 8'h9d);
    rdc(cbc_pkg::CBC_ADDR_CURR, 8'h3c);
    host.rd_two(cbc_pkg::CBC_ADDR_BAND, w, ok);
    chk("burst read", 16'h9d3c, w);
    host.wr_reg(7'h49, cbc_pkg::CBC_ADDR_BAND, 8'h00, ok);
    chk("foreign address ack", 16'h0000, {15'h0000, ok});
    rdc(cbc_pkg::CBC_ADDR_BAND, 8'h9d);
    rdc(8'h07, 8'h00);
    foreach (rows[i]) begin
      temp = rows[i].t;
      lo = rows[i].lo;
      repeat (2) @(negedge clk);
      chk("fault", rows[i].f, flt);
      chk("enable", !rows[i].f, en);
      if (!rows[i].f) begin
        chk("band", rows[i].b, band);
        chk("term", rows[i].mv, mv);
        chk("limit", rows[i].ma, ma);
        chk("eoc", 11'h0b9, eoc);
      end
    end
    temp = 8'sh05;
    lo = 1'b0;
    tc = 3'h7;
    repeat (2) @(negedge clk);
    chk("invalid term", 16'h0000, {3'h0, mv});
    chk("invalid enable", 16'h0000, {15'h0000, en});
    tc = 3'h0;
    wr(cbc_pkg::CBC_ADDR_BAND, 8'hc1);
    repeat (2) @(negedge clk);
    chk("eoc top code", 11'h172, eoc);
    temp = 8'sh30;
    repeat (2) @(negedge clk);
    chk("warm term", 13'hf64, mv);
    temp = 8'sh37;
    repeat (2) @(negedge clk);
    chk("hot term", 13'hfa0, mv);
    temp = 8'sh05;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset enable", 16'h0000, {15'h0000, en});
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    chk("reset eoc", 11'h032, eoc);
    rdc(cbc_pkg::CBC_ADDR_CFG_EN, 8'h00);
    rdc(cbc_pkg::CBC_ADDR_BAND, 8'h00);
    wr(cbc_pkg::CBC_ADDR_CFG_EN, 8'h01);
    rdc(cbc_pkg::CBC_ADDR_BAND, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
